// [testbench/async_uart_receiver_tb.sv]
// Self-checking bench for the asynchronous serial receiver
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_map.svh"
module async_uart_receiver_tb;
  // Divisor low of 1 gives two clocks per tick, sixteen ticks per bit
  localparam int bit_clocks = 32;
  logic clock, reset, psel, penable, pwrite, rx_line, pready, pslverr, receive_irq, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  int mismatches, compares, cycles;

  async_uart_receiver u_async_uart_receiver (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .serial_input_pin(rx_line), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .receive_irq(receive_irq)
  );
  // The receive pin is a pure input here; the model plays the pulled-up line
  serial_tx_model #(.bit_clocks(bit_clocks)) u_serial_tx_model (.clock(clock), .line(rx_line));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic conclude;
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // Whole run is well under this many cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches = mismatches + 1;
      conclude();
    end
  end

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp);
    check_word({31'h0, got}, {31'h0, exp});
  endtask : check_bit

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    apb(1'b1, addr, data);
  endtask : wr

  task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0000_0000);
    check_word(rdat, exp);
  endtask : rd

  task automatic send(input logic [8:0] value, input int bits, input logic stop_level);
    u_serial_tx_model.send(value, bits, stop_level);
    repeat (4) @(posedge clock);
  endtask : send

  task automatic test_reset_map;
    for (int a = 0; a <= 36; a += 4) begin
      rd(a[7:0], `RESET_WORD);
      check_bit(rerr, 1'b0);
    end
    rd(8'h28, 32'h0000_0000);
    check_bit(rerr, 1'b1);
    check_bit(receive_irq, 1'b0);
    wr(`OFS_BAUD_CONTROL, 32'h0000_00A5);
    rd(`OFS_BAUD_CONTROL, 32'h0000_00A5);
    wr(`OFS_BAUD_RATE_DIVISOR_LOW, 32'h0000_0001);
    rd(`OFS_BAUD_RATE_DIVISOR_LOW, 32'h0000_0001);
    wr(`OFS_RECEIVE_STATUS_CONTROL, 32'h0000_0097);
    rd(`OFS_RECEIVE_STATUS_CONTROL, 32'h0000_0090);
  endtask : test_reset_map

  task automatic test_basic_irq;
    wr(`OFS_PERIPHERAL_IRQ_ENABLE_ONE, 32'h0000_0020);
    wr(`OFS_INTERRUPT_CONTROL, 32'h0000_00C0);
    send(9'h0A5, 8, 1'b1);
    rd(`OFS_PERIPHERAL_IRQ_FLAGS_ONE, 32'h0000_0020);
    check_bit(receive_irq, 1'b1);
    wr(`OFS_PERIPHERAL_IRQ_FLAGS_ONE, 32'h0000_0000);
    wr(`OFS_INTERRUPT_CONTROL, 32'h0000_0080);
    // The request flop follows the enables one clock late
    repeat (2) @(posedge clock);
    check_bit(receive_irq, 1'b0);
    rd(`OFS_PERIPHERAL_IRQ_FLAGS_ONE, 32'h0000_0020);
    wr(`OFS_INTERRUPT_CONTROL, 32'h0000_00C0);
    rd(`OFS_RECEIVE_DATA_REGISTER, 32'h0000_00A5);
    rd(`OFS_PERIPHERAL_IRQ_FLAGS_ONE, 32'h0000_0000);
    check_bit(receive_irq, 1'b0);
  endtask : test_basic_irq

  task automatic test_framing;
    send(9'h03C, 8, 1'b0);
    send(9'h05A, 8, 1'b1);
    rd(`OFS_RECEIVE_STATUS_CONTROL, 32'h0000_0094);
    rd(`OFS_RECEIVE_DATA_REGISTER, 32'h0000_003C);
    rd(`OFS_RECEIVE_STATUS_CONTROL, 32'h0000_0090);
    rd(`OFS_RECEIVE_DATA_REGISTER, 32'h0000_005A);
    send(9'h0F0, 8, 1'b0);
    wr(`OFS_RECEIVE_STATUS_CONTROL, 32'h0000_0000);
    rd(`OFS_RECEIVE_STATUS_CONTROL, 32'h0000_0000);
    wr(`OFS_RECEIVE_STATUS_CONTROL, 32'h0000_0090);
    rd(`OFS_RECEIVE_DATA_REGISTER, 32'h0000_0000);
  endtask : test_framing

  task automatic test_false_start;
    // Low for well under half a bit: majority at mid start sees mark
    u_serial_tx_model.glitch(6);
    repeat (2 * bit_clocks) @(posedge clock);
    rd(`OFS_PERIPHERAL_IRQ_FLAGS_ONE, 32'h0000_0000);
    rd(`OFS_RECEIVE_STATUS_CONTROL, 32'h0000_0090);
    send(9'h011, 8, 1'b1);
    rd(`OFS_RECEIVE_DATA_REGISTER, 32'h0000_0011);
    // Clocked mode keeps the receiver off, so a whole frame leaves nothing behind
    wr(`OFS_TRANSMIT_STATUS_CONTROL, 32'h0000_0010);
    send(9'h022, 8, 1'b1);
    wr(`OFS_PERIPHERAL_IRQ_FLAGS_ONE, 32'h0000_0020);
    rd(`OFS_PERIPHERAL_IRQ_FLAGS_ONE, 32'h0000_0000);
    rd(`OFS_TRANSMIT_STATUS_CONTROL, 32'h0000_0010);
    wr(`OFS_TRANSMIT_STATUS_CONTROL, 32'h0000_0000);
    rd(`OFS_RECEIVE_DATA_REGISTER, 32'h0000_0000);
  endtask : test_false_start

  task automatic test_overrun;
    send(9'h0C1, 8, 1'b0);
    send(9'h0C2, 8, 1'b1);
    send(9'h0C3, 8, 1'b1);
    send(9'h0C4, 8, 1'b1);
    rd(`OFS_RECEIVE_STATUS_CONTROL, 32'h0000_0096);
    wr(`OFS_RECEIVE_STATUS_CONTROL, 32'h0000_0080);
    rd(`OFS_PERIPHERAL_IRQ_FLAGS_ONE, 32'h0000_0000);
    rd(`OFS_RECEIVE_STATUS_CONTROL, 32'h0000_0084);
    wr(`OFS_RECEIVE_STATUS_CONTROL, 32'h0000_0090);
    rd(`OFS_RECEIVE_DATA_REGISTER, 32'h0000_00C1);
    rd(`OFS_RECEIVE_DATA_REGISTER, 32'h0000_00C2);
    rd(`OFS_PERIPHERAL_IRQ_FLAGS_ONE, 32'h0000_0000);
    send(9'h0C5, 8, 1'b1);
    rd(`OFS_RECEIVE_DATA_REGISTER, 32'h0000_00C5);
  endtask : test_overrun

  task automatic test_nine_bit;
    wr(`OFS_RECEIVE_STATUS_CONTROL, 32'h0000_00D0);
    send(9'h1C3, 9, 1'b1);
    send(9'h0AA, 9, 1'b1);
    rd(`OFS_RECEIVE_STATUS_CONTROL, 32'h0000_00D1);
    rd(`OFS_RECEIVE_DATA_REGISTER, 32'h0000_00C3);
    rd(`OFS_RECEIVE_STATUS_CONTROL, 32'h0000_00D0);
    rd(`OFS_RECEIVE_DATA_REGISTER, 32'h0000_00AA);
  endtask : test_nine_bit

  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    mismatches = 0;
    compares = 0;
    cycles = 0;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    test_reset_map();
    test_basic_irq();
    test_framing();
    test_false_start();
    test_overrun();
    test_nine_bit();
    conclude();
  end
endmodule : async_uart_receiver_tb
`default_nettype wire

// [testbench/serial_tx_model.sv]
// Remote asynchronous transmitter model that drives the receiver's serial line
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model #(
  parameter int bit_clocks = 32
) (
  input wire logic clock,
  output var logic line
);
  // Line idles at mark, as an undriven pulled-up receive pin would
  initial line = 1'b1;

  task automatic hold_bit(input logic level, input int clocks);
    line <= level;
    repeat (clocks) @(posedge clock);
  endtask : hold_bit

  task automatic send(input logic [8:0] value, input int bits, input logic stop_level);
    @(posedge clock);
    hold_bit(1'b0, bit_clocks);
    for (int i = 0; i < bits; i++) begin
      hold_bit(value[i], bit_clocks);
    end
    hold_bit(stop_level, bit_clocks);
    // Short mark gap so a low stop still leaves a falling edge for the next start
    hold_bit(1'b1, bit_clocks / 2);
  endtask : send

  task automatic glitch(input int clocks);
    @(posedge clock);
    hold_bit(1'b0, clocks);
    hold_bit(1'b1, 1);
  endtask : glitch
endmodule : serial_tx_model
`default_nettype wire

// [verilog/async_uart_receiver.sv]
// Asynchronous serial receiver with APB register access
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_map.svh"

// Functional notes
// - Line is oversampled at sixteen times the baud rate; one bit per period.
// - Completed characters enter a two-entry first-in first-out store.
// - Shifter and store are hidden; data is read via the data register.
// - A falling edge on the idle line starts a character.
// - Half a bit later the line must still be low, else quietly restart.
// - Each following bit is voted at its centre, one period apart.
// - Stop position sampled low marks a framing error, high marks clean.
// - After the stop bit the character is stored and pending flag rises.
// - Reading the data register returns and removes the oldest character.
// - While overrun is pending no new character is accepted.
// - Pending flag is high exactly while enabled and store not empty.
// - Interrupt only when receive, peripheral and global enables are all set.
// - Each entry keeps its framing bit; oldest entry's bit is shown.
// - Framing status is read-only, does not stop reception, follows store.
// - Dropping port enable resets and clears framing; receive enable only resets the receiver.
// - A framing error alone raises no interrupt.
// - A third character with the store full sets overrun; enables clear it.
// - Nine-bit mode shifts nine bits and shows the oldest ninth bit.
// - Least significant data bit arrives first after the start bit.
module async_uart_receiver (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic serial_input_pin,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic receive_irq
);
  logic serial_port_enable;
  logic nine_bit_receive_select;
  logic continuous_receive_enable;
  logic clocked_mode_select;
  logic [7:0] baud_rate_divisor_low;
  logic [7:0] baud_rate_divisor_high;
  logic [7:0] baud_control;
  logic receive_interrupt_enable;
  logic global_interrupt_enable;
  logic peripheral_interrupt_enable;
  logic overrun_error_status;

  logic [15:0] baud_count;
  logic tick;
  logic line_meta;
  logic line_sync;
  logic line_prev;
  logic [2:0] samples;
  logic majority;
  uart_rx_pkg::rx_state_e state;
  logic [3:0] tick_count;
  logic [3:0] bit_index;
  logic [8:0] receive_shift_register;

  logic rx_enable;
  logic falling;
  logic frame_done;
  logic push;
  logic pop;
  logic overrun_set;
  logic receive_pending_flag;
  logic framing_error_status;
  logic received_ninth_bit;
  logic store_empty;
  logic store_full;
  uart_rx_pkg::rx_entry_t head_entry;
  uart_rx_pkg::rx_entry_t push_entry;

  logic access;
  logic done;
  logic wr_done;
  logic rd_done;
  logic mapped;
  logic [31:0] next_prdata;
  logic [3:0] last_bit;
  logic pop_armed;

  // Bus handshake: access phase always takes two cycles, pready from a flop
  assign access = psel && penable && !pready;
  assign done = psel && penable && pready;
  assign wr_done = done && pwrite;
  assign rd_done = done && !pwrite;

  assign rx_enable = serial_port_enable && continuous_receive_enable && !clocked_mode_select;
  assign receive_pending_flag = rx_enable && !store_empty;
  assign framing_error_status = head_entry[9] && !store_empty;
  assign received_ninth_bit = head_entry[8] && !store_empty;

  always_comb begin
    mapped = 1'b1;
    next_prdata = `RESET_WORD;
    case (paddr)
      `OFS_RECEIVE_STATUS_CONTROL: begin
        next_prdata[`BIT_SERIAL_PORT_ENABLE] = serial_port_enable;
        next_prdata[`BIT_NINE_BIT_RECEIVE_SELECT] = nine_bit_receive_select;
        next_prdata[`BIT_CONTINUOUS_RECEIVE_ENABLE] = continuous_receive_enable;
        next_prdata[`BIT_FRAMING_ERROR_STATUS] = framing_error_status;
        next_prdata[`BIT_OVERRUN_ERROR_STATUS] = overrun_error_status;
        next_prdata[`BIT_RECEIVED_NINTH_BIT] = received_ninth_bit;
      end
      `OFS_RECEIVE_DATA_REGISTER: begin
        next_prdata[7:0] = store_empty ? `RESET_BYTE : head_entry[7:0];
      end
      `OFS_BAUD_RATE_DIVISOR_LOW: next_prdata[7:0] = baud_rate_divisor_low;
      `OFS_BAUD_RATE_DIVISOR_HIGH: next_prdata[7:0] = baud_rate_divisor_high;
      `OFS_TRANSMIT_STATUS_CONTROL: next_prdata[`BIT_CLOCKED_MODE_SELECT] = clocked_mode_select;
      `OFS_BAUD_CONTROL: next_prdata[7:0] = baud_control;
      `OFS_PERIPHERAL_IRQ_ENABLE_ONE: begin
        next_prdata[`BIT_RECEIVE_PENDING] = receive_interrupt_enable;
      end
      `OFS_PERIPHERAL_IRQ_FLAGS_ONE: next_prdata[`BIT_RECEIVE_PENDING] = receive_pending_flag;
      `OFS_INTERRUPT_CONTROL: begin
        next_prdata[`BIT_GLOBAL_INTERRUPT_ENABLE] = global_interrupt_enable;
        next_prdata[`BIT_PERIPHERAL_INTERRUPT_ENABLE] = peripheral_interrupt_enable;
      end
      `OFS_TRANSMIT_DATA_BUFFER: next_prdata = `RESET_WORD;
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `RESET_WORD;
      pop_armed <= 1'b0;
    end else begin
      pready <= access;
      pslverr <= access && !mapped;
      // A character landing after the data was latched must not be popped unseen
      pop_armed <= access && !pwrite && !store_empty;
      if (access && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  // Control registers; the pending flag has no write path at all
  always_ff @(posedge clock) begin
    if (reset) begin
      serial_port_enable <= 1'b0;
      nine_bit_receive_select <= 1'b0;
      continuous_receive_enable <= 1'b0;
      clocked_mode_select <= 1'b0;
      baud_rate_divisor_low <= `RESET_BYTE;
      baud_rate_divisor_high <= `RESET_BYTE;
      baud_control <= `RESET_BYTE;
      receive_interrupt_enable <= 1'b0;
      global_interrupt_enable <= 1'b0;
      peripheral_interrupt_enable <= 1'b0;
    end else if (wr_done) begin
      case (paddr)
        `OFS_RECEIVE_STATUS_CONTROL: begin
          serial_port_enable <= pwdata[`BIT_SERIAL_PORT_ENABLE];
          nine_bit_receive_select <= pwdata[`BIT_NINE_BIT_RECEIVE_SELECT];
          continuous_receive_enable <= pwdata[`BIT_CONTINUOUS_RECEIVE_ENABLE];
        end
        `OFS_BAUD_RATE_DIVISOR_LOW: baud_rate_divisor_low <= pwdata[7:0];
        `OFS_BAUD_RATE_DIVISOR_HIGH: baud_rate_divisor_high <= pwdata[7:0];
        `OFS_TRANSMIT_STATUS_CONTROL: clocked_mode_select <= pwdata[`BIT_CLOCKED_MODE_SELECT];
        `OFS_BAUD_CONTROL: baud_control <= pwdata[7:0];
        `OFS_PERIPHERAL_IRQ_ENABLE_ONE: begin
          receive_interrupt_enable <= pwdata[`BIT_RECEIVE_PENDING];
        end
        `OFS_INTERRUPT_CONTROL: begin
          global_interrupt_enable <= pwdata[`BIT_GLOBAL_INTERRUPT_ENABLE];
          peripheral_interrupt_enable <= pwdata[`BIT_PERIPHERAL_INTERRUPT_ENABLE];
        end
        default: begin
        end
      endcase
    end
  end

  // Oversample tick every divisor+1 clocks, i.e. sixteen ticks per bit
  always_ff @(posedge clock) begin
    if (reset || !serial_port_enable) begin
      baud_count <= 16'h0000;
      tick <= 1'b0;
    end else if (baud_count == {baud_rate_divisor_high, baud_rate_divisor_low}) begin
      baud_count <= 16'h0000;
      tick <= 1'b1;
    end else begin
      baud_count <= baud_count + 16'h0001;
      tick <= 1'b0;
    end
  end

  // Pin synchroniser; line_meta feeds line_sync only
  always_ff @(posedge clock) begin
    if (reset) begin
      line_meta <= 1'b1;
      line_sync <= 1'b1;
      line_prev <= 1'b1;
      samples <= 3'h7;
    end else begin
      line_meta <= serial_input_pin;
      line_sync <= line_meta;
      line_prev <= line_sync;
      if (tick) begin
        samples <= {samples[1:0], line_sync};
      end
    end
  end

  assign falling = line_prev && !line_sync;
  assign majority = (samples[0] && samples[1]) || (samples[0] && samples[2])
                  || (samples[1] && samples[2]);
  assign last_bit = nine_bit_receive_select ? `LAST_BIT_NINE : `LAST_BIT_EIGHT;
  assign frame_done = (state == uart_rx_pkg::rx_stop) && tick && (tick_count == `TICKS_FULL_BIT);

  always_ff @(posedge clock) begin
    if (reset || !rx_enable) begin
      state <= uart_rx_pkg::rx_idle;
      tick_count <= 4'h0;
      bit_index <= 4'h0;
      receive_shift_register <= 9'h000;
    end else begin
      if (tick) begin
        tick_count <= tick_count + 4'h1;
      end
      case (state)
        uart_rx_pkg::rx_idle: begin
          // Overrun holds the receiver here until it is cleared
          if (falling && !overrun_error_status) begin
            state <= uart_rx_pkg::rx_start;
            tick_count <= 4'h0;
            receive_shift_register <= 9'h000;
          end
        end
        uart_rx_pkg::rx_start: begin
          if (tick && tick_count == `TICKS_HALF_BIT) begin
            tick_count <= 4'h0;
            bit_index <= 4'h0;
            state <= majority ? uart_rx_pkg::rx_idle : uart_rx_pkg::rx_data;
          end
        end
        uart_rx_pkg::rx_data: begin
          if (tick && tick_count == `TICKS_FULL_BIT) begin
            tick_count <= 4'h0;
            receive_shift_register[bit_index] <= majority;
            bit_index <= bit_index + 4'h1;
            if (bit_index == last_bit) begin
              state <= uart_rx_pkg::rx_stop;
            end
          end
        end
        uart_rx_pkg::rx_stop: begin
          if (frame_done) begin
            state <= uart_rx_pkg::rx_idle;
          end
        end
        default: begin
          state <= uart_rx_pkg::rx_idle;
        end
      endcase
    end
  end

  assign pop = rd_done && (paddr == `OFS_RECEIVE_DATA_REGISTER) && pop_armed;
  assign push = frame_done && !overrun_error_status && (!store_full || pop);
  assign overrun_set = frame_done && !overrun_error_status && store_full && !pop;
  assign push_entry = {!majority, receive_shift_register};

  // Set wins; the clear is a level while the receiver is disabled
  always_ff @(posedge clock) begin
    if (reset) begin
      overrun_error_status <= 1'b0;
    end else if (overrun_set) begin
      overrun_error_status <= 1'b1;
    end else if (!rx_enable) begin
      overrun_error_status <= 1'b0;
    end
  end

  rx_char_store u_rx_char_store (
    .clock(clock),
    .reset(reset),
    .clear(!serial_port_enable),
    .push(push),
    .push_entry(push_entry),
    .pop(pop),
    .head_entry(head_entry),
    .empty(store_empty),
    .full(store_full)
  );

  // Framing status feeds no term here
  always_ff @(posedge clock) begin
    if (reset) begin
      receive_irq <= 1'b0;
    end else begin
      receive_irq <= receive_pending_flag && receive_interrupt_enable
                   && peripheral_interrupt_enable && global_interrupt_enable;
    end
  end

  sequence s_start_seen;
    state == uart_rx_pkg::rx_start && tick && tick_count == `TICKS_HALF_BIT;
  endsequence

  sequence s_data_read;
    rd_done && paddr == `OFS_RECEIVE_DATA_REGISTER && !store_empty && !push;
  endsequence

  a_start_abort: assert property (@(posedge clock) disable iff (reset)
    s_start_seen ##0 majority && rx_enable |=> state == uart_rx_pkg::rx_idle && !push)
    else $error("false start not abandoned");

  a_start_accept: assert property (@(posedge clock) disable iff (reset)
    s_start_seen ##0 !majority && rx_enable |=> state == uart_rx_pkg::rx_data && bit_index == 4'h0)
    else $error("valid start not followed by data");

  a_edge_starts: assert property (@(posedge clock) disable iff (reset)
    state == uart_rx_pkg::rx_idle && falling && rx_enable && !overrun_error_status
    |=> state == uart_rx_pkg::rx_start)
    else $error("falling edge did not start a character");

  a_push_pending: assert property (@(posedge clock) disable iff (reset)
    push && rx_enable ##1 rx_enable |-> receive_pending_flag)
    else $error("stored character not pending");

  a_read_pops: assert property (@(posedge clock) disable iff (reset)
    s_data_read ##0 store_full |=> !store_full)
    else $error("data read did not remove a character");

  a_overrun_blocks: assert property (@(posedge clock) disable iff (reset)
    overrun_error_status |-> !push ##1 (state != uart_rx_pkg::rx_start || $past(state) != uart_rx_pkg::rx_idle))
    else $error("reception continued under overrun");

  a_overrun_sets: assert property (@(posedge clock) disable iff (reset)
    frame_done && store_full && !pop && rx_enable |=> overrun_error_status)
    else $error("third character did not set overrun");

  a_port_off_clear: assert property (@(posedge clock) disable iff (reset)
    !serial_port_enable |=> !framing_error_status && store_empty)
    else $error("port disable did not clear framing status");

  a_framing_error_status_captured: assert property (@(posedge clock) disable iff (reset)
    push && store_empty && !pop |=> framing_error_status == $past(!majority))
    else $error("stop sample not recorded as framing status");

  a_irq_gate: assert property (@(posedge clock) disable iff (reset)
    receive_irq |-> $past(receive_pending_flag && global_interrupt_enable
                          && peripheral_interrupt_enable && receive_interrupt_enable))
    else $error("interrupt raised without all enables");

  a_pready_pulse: assert property (@(posedge clock) disable iff (reset)
    pready |=> !pready)
    else $error("pready held beyond one cycle");
endmodule : async_uart_receiver
`default_nettype wire

// [verilog/rx_char_store.sv]
// Two-entry first-in first-out store for received characters
`timescale 1ns/1ps
`default_nettype none
module rx_char_store (
  input wire logic clock,
  input wire logic reset,
  input wire logic clear,
  input wire logic push,
  input wire uart_rx_pkg::rx_entry_t push_entry,
  input wire logic pop,
  output uart_rx_pkg::rx_entry_t head_entry,
  output logic empty,
  output logic full
);
  uart_rx_pkg::rx_entry_t slots [0:1];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic do_push;
  logic do_pop;

  assign do_pop = pop && (count != 2'h0);
  assign do_push = push && ((count != 2'h2) || do_pop);
  assign empty = (count == 2'h0);
  assign full = (count == 2'h2);
  assign head_entry = slots[rd_ptr];

  always_ff @(posedge clock) begin
    if (reset || clear) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (do_push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (do_pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (do_push && !do_pop) begin
        count <= count + 2'h1;
      end else if (do_pop && !do_push) begin
        count <= count - 2'h1;
      end
    end
  end

  // Slots are not reset; count marks which hold valid characters
  always_ff @(posedge clock) begin
    if (do_push) begin
      slots[wr_ptr] <= push_entry;
    end
  end
endmodule : rx_char_store
`default_nettype wire

// [verilog/uart_rx_map.svh]
// Register offsets, field positions, reset values and timing counts of the serial receiver
`ifndef UART_RX_MAP_SVH
`define UART_RX_MAP_SVH

`define OFS_RECEIVE_STATUS_CONTROL 8'h00
`define OFS_RECEIVE_DATA_REGISTER 8'h04
`define OFS_BAUD_RATE_DIVISOR_LOW 8'h08
`define OFS_BAUD_RATE_DIVISOR_HIGH 8'h0C
`define OFS_TRANSMIT_STATUS_CONTROL 8'h10
`define OFS_BAUD_CONTROL 8'h14
`define OFS_PERIPHERAL_IRQ_ENABLE_ONE 8'h18
`define OFS_PERIPHERAL_IRQ_FLAGS_ONE 8'h1C
`define OFS_INTERRUPT_CONTROL 8'h20
`define OFS_TRANSMIT_DATA_BUFFER 8'h24

// receive_status_control fields
`define BIT_SERIAL_PORT_ENABLE 7
`define BIT_NINE_BIT_RECEIVE_SELECT 6
`define BIT_CONTINUOUS_RECEIVE_ENABLE 4
`define BIT_FRAMING_ERROR_STATUS 2
`define BIT_OVERRUN_ERROR_STATUS 1
`define BIT_RECEIVED_NINTH_BIT 0
// transmit_status_control field
`define BIT_CLOCKED_MODE_SELECT 4
// peripheral_irq_enable_one / peripheral_irq_flags_one field
`define BIT_RECEIVE_PENDING 5
// interrupt control fields
`define BIT_GLOBAL_INTERRUPT_ENABLE 7
`define BIT_PERIPHERAL_INTERRUPT_ENABLE 6

`define RESET_BYTE 8'h00
`define RESET_WORD 32'h0000_0000

// Oversample ticks: centre of start bit, then a full bit period
`define TICKS_HALF_BIT 4'h8
`define TICKS_FULL_BIT 4'hF
`define LAST_BIT_EIGHT 4'h7
`define LAST_BIT_NINE 4'h8

`endif

// [verilog/uart_rx_pkg.sv]
// Types shared by the serial receiver files
package uart_rx_pkg;
  typedef enum logic [1:0] {
    rx_idle = 2'b00,
    rx_start = 2'b01,
    rx_data = 2'b10,
    rx_stop = 2'b11
  } rx_state_e;
  typedef logic [9:0] rx_entry_t;
endpackage : uart_rx_pkg
